// ---- racq_top.sv ----
// Run-type acquisition control: run start/stop, histogram and record steering, buffer accounting
`timescale 1ns/100ps

module racq_top #(
    parameter int BUF_WORDS   = racq_pkg::BUF_WORDS_DOC,
    parameter int SPILL_WORDS = racq_pkg::SPILL_WORDS_DOC
) (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    // APB slave
    input  wire logic                                 psel_i,
    input  wire logic                                 penable_i,
    input  wire logic                                 pwrite_i,
    input  wire logic [7:0]                           paddr_i,
    input  wire logic [31:0]                          pwdata_i,
    output logic [31:0]                               prdata_o,
    output logic                                      pready_o,
    output logic                                      pslverr_o,
    // Qualified events from the trigger logic
    input  wire logic                                 ev_valid_i,
    input  racq_pkg::racq_event_t                     ev_i,
    output logic                                      ev_ready_o,
    // Live sample stream for pulse-shape analysis
    input  wire logic [racq_pkg::NCH-1:0][15:0]       sample_i,
    input  wire logic [racq_pkg::NCH-1:0][15:0]       baseline_i,
    input  wire logic [racq_pkg::NCH-1:0]             trig_i,
    // Live-time gating levels
    input  wire logic [racq_pkg::NCH-1:0]             chan_oor_i,
    input  wire logic [racq_pkg::NCH-1:0]             chan_buf_full_i,
    // Outputs to spectrum memory and record writer
    output racq_pkg::racq_hist_t                      hist_o,
    output racq_pkg::racq_rec_t                       rec_o,
    output racq_pkg::racq_psa_t [racq_pkg::NCH-1:0]   pulse_shape_result_o,
    // Buffer drain side: one word moved to host per cycle that drain_i and drain_ready_o are both high
    input  wire logic                                 drain_i,
    output logic                                      drain_ready_o,
    output logic                                      spill_done_o,
    output logic [31:0]                               wr_ptr_o,
    output logic [31:0]                               rd_ptr_o,
    output logic                                      group_trig_o,
    output logic                                      trace_capture_o,
    output logic                                      led_red_o
);
    // Elaboration checks on sizing
    if (BUF_WORDS < 2 || BUF_WORDS > 32'h7FFF_FFFF) begin : g_chk_buf
        $error("BUF_WORDS out of range");
    end
    if (SPILL_WORDS < 1 || SPILL_WORDS > BUF_WORDS) begin : g_chk_spill
        $error("SPILL_WORDS out of range");
    end

    localparam logic [31:0] BUF_W   = 32'(BUF_WORDS);
    localparam logic [31:0] SPILL_W = 32'(SPILL_WORDS);

    typedef struct packed {
        racq_pkg::racq_state_t                 state;
        logic                                  running;
        logic                                  err;
        logic [15:0]                           run_task_code;
        logic [15:0]                           trace_len;
        logic [3:0]                            bin_shift;
        logic [6:0]                            cfg;
        racq_pkg::racq_event_t                 ev;
        logic [racq_pkg::NCH:0]                hmask;
        logic [racq_pkg::NCH-1:0]              rmask;
        racq_pkg::racq_hist_t                  hist;
        racq_pkg::racq_rec_t                   rec;
        logic [31:0]                           wr_ptr;
        logic [31:0]                           rd_ptr;
        logic [31:0]                           fill;
        logic [31:0]                           spill_cnt;
        logic [31:0]                           spills;
        logic                                  spill_done;
        logic [racq_pkg::NCH-1:0][31:0]        live;
        logic [racq_pkg::NCH-1:0][4:0]         psa_cnt;
        racq_pkg::racq_psa_t [racq_pkg::NCH-1:0] psa_acc;
        racq_pkg::racq_psa_t [racq_pkg::NCH-1:0] pulse_shape_result;
        logic [31:0]                           prdata;
    } racq_state_all_t;

    racq_state_all_t s_reg;
    racq_state_all_t s_next;

    // Decoded mode of the selected run
    logic is_mca;
    logic is_text;
    logic is_group;
    logic is_list;
    logic group_on;
    logic sum_on;
    logic paused;
    logic buf_full;
    logic [15:0] trace_eff;
    logic [31:0] rec_len;
    logic [31:0] wr_sum;
    logic [31:0] rd_sum;
    logic apb_wr;
    logic apb_setup;
    logic addr_ok;

    always_comb begin
        is_mca   = (s_reg.run_task_code == racq_pkg::RT_MCA);
        is_text  = (s_reg.run_task_code == racq_pkg::RT_TEXT);
        is_group = (s_reg.run_task_code == racq_pkg::RT_GROUP);
        is_list  = is_group || is_text || (s_reg.run_task_code == racq_pkg::RT_LIST);
        group_on = s_reg.cfg[racq_pkg::CFG_GTRIG] || is_group;
        sum_on   = s_reg.cfg[racq_pkg::CFG_SUMH] || is_group;
        trace_eff = is_text ? 16'h0000 : s_reg.trace_len;
        rec_len = is_group ? 32'({(racq_pkg::HDR_WORDS + trace_eff), 2'b00})
                           : 32'(racq_pkg::HDR_WORDS + trace_eff);
        // Room for a whole event: general modes may emit one record per channel
        buf_full = (BUF_W - s_reg.fill) < (is_group ? rec_len : {rec_len[29:0], 2'b00});
        paused   = s_reg.running && is_list && buf_full;
    end

    // APB decode; registers answer with no wait states
    always_comb begin
        apb_setup = psel_i && !penable_i;
        apb_wr    = psel_i && penable_i && pwrite_i;
        addr_ok   = (paddr_i[1:0] == 2'b00) && (paddr_i <= racq_pkg::OFS_LIVE3);
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign prdata_o  = s_reg.prdata;
    assign ev_ready_o = (s_reg.state == racq_pkg::ST_IDLE) && !paused;
    assign hist_o    = s_reg.hist;
    assign rec_o     = s_reg.rec;
    assign pulse_shape_result_o = s_reg.pulse_shape_result;
    assign drain_ready_o = (s_reg.fill != 32'h0000_0000);
    assign spill_done_o  = s_reg.spill_done;
    assign wr_ptr_o  = s_reg.wr_ptr;
    assign rd_ptr_o  = s_reg.rd_ptr;
    assign group_trig_o = group_on;
    assign trace_capture_o = s_reg.running && is_list && (trace_eff != 16'h0000);
    assign led_red_o = paused;

    // Bin of one energy at the current binning and mode width
    function automatic logic [14:0] racq_bin(input logic [17:0] e, input logic [3:0] sh,
                                             input logic grp);
        logic [17:0] b;
        b = e >> sh;
        racq_bin = grp ? {1'b0, b[racq_pkg::BIN_W_GRP-1:0]}
                       : b[racq_pkg::BIN_W_GEN-1:0];
        return racq_bin;
    endfunction : racq_bin

    // Next-state logic for the whole block
    always_comb begin
        logic [racq_pkg::NCH-1:0] acc;
        logic [racq_pkg::NCH-1:0] lt_run;
        logic                     kill;
        logic [17:0]              esum;
        logic [15:0]              d;
        logic                     rec_fire;
        logic [31:0]              q;
        int                       c;
        acc = '0;
        lt_run = '0;
        kill = 1'b0;
        esum = '0;
        d = '0;
        rec_fire = 1'b0;
        q = '0;
        c = 0;
        s_next = s_reg;
        s_next.hist.valid = 1'b0;
        s_next.rec.valid = 1'b0;
        s_next.spill_done = 1'b0;

        // Register reads captured in the setup phase
        if (apb_setup) begin
            case (paddr_i)
                racq_pkg::OFS_TASK:   q = {16'h0000, s_reg.run_task_code};
                racq_pkg::OFS_TRACE:  q = {16'h0000, s_reg.trace_len};
                racq_pkg::OFS_BIN:    q = {28'h000_0000, s_reg.bin_shift};
                racq_pkg::OFS_CFG:    q = {25'h000_0000, s_reg.cfg};
                racq_pkg::OFS_STATUS: q = {27'h000_0000, led_red_o, group_on, s_reg.err,
                                           paused, s_reg.running};
                racq_pkg::OFS_SPILLS: q = s_reg.spills;
                racq_pkg::OFS_FILL:   q = s_reg.fill;
                racq_pkg::OFS_LIVE0,
                racq_pkg::OFS_LIVE0 + 8'h04,
                racq_pkg::OFS_LIVE0 + 8'h08,
                racq_pkg::OFS_LIVE3:  q = s_reg.live[paddr_i[3:2]];
                default:              q = 32'h0000_0000;
            endcase
            s_next.prdata = q;
        end

        // Register writes; the run only ends here, by host command
        if (apb_wr && addr_ok) begin
            case (paddr_i)
                racq_pkg::OFS_CTRL: begin
                    if (pwdata_i[racq_pkg::CTRL_STOP]) begin
                        s_next.running = 1'b0;
                    end else if (pwdata_i[racq_pkg::CTRL_START] && !s_reg.running) begin
                        if (is_mca || is_list) begin
                            s_next.running = 1'b1;
                            s_next.err = 1'b0;
                            s_next.live = '0;
                            s_next.spills = '0;
                        end else begin
                            s_next.err = 1'b1;
                        end
                    end
                end
                racq_pkg::OFS_TASK:  s_next.run_task_code = pwdata_i[15:0];
                racq_pkg::OFS_TRACE: s_next.trace_len = pwdata_i[15:0];
                racq_pkg::OFS_BIN:   s_next.bin_shift = pwdata_i[3:0];
                racq_pkg::OFS_CFG:   s_next.cfg = pwdata_i[6:0];
                default: ;
            endcase
        end

        // Event acceptance and per-channel gating
        case (s_reg.state)
            racq_pkg::ST_IDLE: begin
                if (ev_valid_i && ev_ready_o && s_reg.running) begin
                    s_next.ev = ev_i;
                    if (is_group) begin
                        kill = ev_i.veto
                            || |(ev_i.hit & ev_i.pileup & s_reg.cfg[3:0])
                            || (|(ev_i.hit & ev_i.oor) && !s_reg.cfg[racq_pkg::CFG_ACCOOR]);
                        acc = (kill || !(|ev_i.hit)) ? '0 : ev_i.hit;
                        s_next.rmask = (|acc) ? 4'b0001 : 4'b0000;
                    end else begin
                        for (c = 0; c < racq_pkg::NCH; c++) begin
                            acc[c] = ev_i.hit[c] && !ev_i.veto
                                && !(ev_i.pileup[c] && s_reg.cfg[racq_pkg::CFG_REJ + c])
                                && !(ev_i.oor[c] && !s_reg.cfg[racq_pkg::CFG_ACCOOR]);
                            if (!acc[c]) begin
                                s_next.ev.energy[c] = 16'h0000;
                            end
                        end
                        s_next.rmask = is_list ? acc : '0;
                    end
                    s_next.hmask = {sum_on && (|acc), acc};
                    if (|acc) begin
                        s_next.state = racq_pkg::ST_HIST;
                    end
                end
            end
            // One spectrum increment per cycle, lowest channel first
            racq_pkg::ST_HIST: begin
                // General modes zeroed rejected channels at acceptance; group mode sums all four energies, hit or not
                for (c = 0; c < racq_pkg::NCH; c++) begin
                    esum = esum + 18'(s_reg.ev.energy[c]);
                end
                for (c = racq_pkg::NCH; c >= 0; c--) begin
                    if (s_reg.hmask[c]) begin
                        s_next.hist.chan = 3'(c);
                    end
                end
                if (s_next.hist.chan == racq_pkg::SUM_CHAN) begin
                    s_next.hist.bin = racq_bin(esum, s_reg.bin_shift, is_group);
                end else begin
                    s_next.hist.bin = racq_bin(18'(s_reg.ev.energy[s_next.hist.chan[1:0]]),
                                               s_reg.bin_shift, is_group);
                end
                s_next.hist.valid = 1'b1;
                s_next.hmask[s_next.hist.chan] = 1'b0;
                if (s_next.hmask == '0) begin
                    s_next.state = (s_reg.rmask != '0) ? racq_pkg::ST_REC : racq_pkg::ST_IDLE;
                end
            end
            // One record per cycle; space was checked at acceptance
            racq_pkg::ST_REC: begin
                for (c = racq_pkg::NCH - 1; c >= 0; c--) begin
                    if (s_reg.rmask[c]) begin
                        s_next.rec.chan = 2'(c);
                    end
                end
                for (c = 0; c < racq_pkg::NCH; c++) begin
                    esum = esum + 18'(s_reg.ev.energy[c]);
                end
                s_next.rec.group = is_group;
                s_next.rec.energy = is_group ? esum
                                             : 18'(s_reg.ev.energy[s_next.rec.chan]);
                s_next.rec.hit_pattern = {s_reg.ev.gate, s_reg.ev.hit, 4'h0,
                    is_group ? 4'hF : 4'(4'b0001 << s_next.rec.chan)};
                s_next.rec.pulse_shape_result = s_reg.pulse_shape_result[s_next.rec.chan];
                s_next.rec.trace_words = trace_eff;
                s_next.rec.valid = 1'b1;
                rec_fire = 1'b1;
                s_next.rmask[s_next.rec.chan] = 1'b0;
                if (s_next.rmask == '0) begin
                    s_next.state = racq_pkg::ST_IDLE;
                end
            end
            default: s_next.state = racq_pkg::ST_IDLE;
        endcase

        // Buffer positions; drain runs whether or not a run is active
        wr_sum = s_reg.wr_ptr + rec_len;
        rd_sum = s_reg.rd_ptr + 32'h0000_0001;
        if (rec_fire) begin
            s_next.wr_ptr = (wr_sum >= BUF_W) ? wr_sum - BUF_W : wr_sum;
        end
        if (drain_i && drain_ready_o) begin
            s_next.rd_ptr = (rd_sum >= BUF_W) ? rd_sum - BUF_W : rd_sum;
            if (s_reg.spill_cnt == SPILL_W - 32'h0000_0001) begin
                s_next.spill_cnt = '0;
                s_next.spill_done = 1'b1;
                s_next.spills = s_reg.spills + 32'h0000_0001;
            end else begin
                s_next.spill_cnt = s_reg.spill_cnt + 32'h0000_0001;
            end
        end
        s_next.fill = s_reg.fill + (rec_fire ? rec_len : 32'h0000_0000)
                    - ((drain_i && drain_ready_o) ? 32'h0000_0001 : 32'h0000_0000);

        // Live time; group mode links all channels together
        for (c = 0; c < racq_pkg::NCH; c++) begin
            lt_run[c] = s_reg.running && !paused
                && !chan_oor_i[c] && !chan_buf_full_i[c];
        end
        if (is_group && !(&lt_run)) begin
            lt_run = '0;
        end
        for (c = 0; c < racq_pkg::NCH; c++) begin
            if (lt_run[c]) begin
                s_next.live[c] = s_reg.live[c] + 32'h0000_0001;
            end
        end

        // Pulse shape on the live stream, independent of trace length
        for (c = 0; c < racq_pkg::NCH; c++) begin
            d = (sample_i[c] > baseline_i[c]) ? sample_i[c] - baseline_i[c] : 16'h0000;
            if (trig_i[c] && s_reg.psa_cnt[c] == 5'h00) begin
                s_next.psa_cnt[c] = 5'h01;
                s_next.psa_acc[c] = '0;
                s_next.psa_acc[c].sum_a = 24'(d);
                s_next.psa_acc[c].amp = d;
            end else if (s_reg.psa_cnt[c] != 5'h00) begin
                if (s_reg.psa_cnt[c] < racq_pkg::PSA_HALF) begin
                    s_next.psa_acc[c].sum_a = s_reg.psa_acc[c].sum_a + 24'(d);
                end else begin
                    s_next.psa_acc[c].sum_b = s_reg.psa_acc[c].sum_b + 24'(d);
                end
                if (d > s_reg.psa_acc[c].amp) begin
                    s_next.psa_acc[c].amp = d;
                end
                if (s_reg.psa_cnt[c] == {racq_pkg::PSA_HALF[3:0], 1'b0}) begin
                    s_next.psa_cnt[c] = 5'h00;
                    s_next.pulse_shape_result[c] = s_reg.psa_acc[c];
                    s_next.pulse_shape_result[c].ratio = (s_reg.psa_acc[c].sum_a == 24'h00_0000) ? 16'h0000
                        : 16'(({s_reg.psa_acc[c].sum_b, 8'h00})
                              / {8'h00, s_reg.psa_acc[c].sum_a});
                end else begin
                    s_next.psa_cnt[c] = s_reg.psa_cnt[c] + 5'h01;
                end
            end
        end
    end

    // State register with constant reset values
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.state <= racq_pkg::ST_IDLE;
            s_reg.run_task_code <= racq_pkg::TASK_RST;
            s_reg.trace_len <= racq_pkg::TRACE_RST;
            s_reg.bin_shift <= racq_pkg::BIN_RST;
            s_reg.cfg <= racq_pkg::CFG_RST;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : racq_top

// ---- racq_pkg.sv ----
// Shared constants, types and register map of the run-type acquisition control block
package racq_pkg;
    localparam int NCH = 4;
    // Run task codes
    localparam logic [15:0] RT_MCA   = 16'h0301;
    localparam logic [15:0] RT_LIST  = 16'h0400;
    localparam logic [15:0] RT_TEXT  = 16'h0401;
    localparam logic [15:0] RT_GROUP = 16'h0402;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TASK    = 8'h04;
    localparam logic [7:0] OFS_TRACE   = 8'h08;
    localparam logic [7:0] OFS_BIN     = 8'h0C;
    localparam logic [7:0] OFS_CFG     = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_SPILLS  = 8'h18;
    localparam logic [7:0] OFS_FILL    = 8'h1C;
    localparam logic [7:0] OFS_LIVE0   = 8'h20;
    localparam logic [7:0] OFS_LIVE3   = 8'h2C;
    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int CFG_REJ    = 0;  // 4-bit pileup reject mask
    localparam int CFG_ACCOOR = 4;
    localparam int CFG_GTRIG  = 5;
    localparam int CFG_SUMH   = 6;
    // Reset values
    localparam logic [15:0] TASK_RST  = 16'h0301;
    localparam logic [15:0] TRACE_RST = 16'h0000;
    localparam logic [3:0]  BIN_RST   = 4'h1;
    localparam logic [6:0]  CFG_RST   = 7'h0F;
    // Record header size in 32-bit words; buffer and spill sizes in bytes, then in words
    localparam logic [15:0] HDR_WORDS = 16'h0010;
    localparam int BUF_BYTES   = 256 * 1024 * 1024;
    localparam int SPILL_BYTES = 2 * 1024 * 1024;
    localparam int BUF_WORDS_DOC   = BUF_BYTES / 4;
    localparam int SPILL_WORDS_DOC = SPILL_BYTES / 4;
    // Histogram bin widths: 32Ki general, 16Ki group
    localparam int BIN_W_GEN = 15;
    localparam int BIN_W_GRP = 14;
    localparam logic [2:0] SUM_CHAN = 3'h4;
    // Pulse-shape window: samples per sum
    localparam logic [4:0] PSA_HALF = 5'h04;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HIST = 3'b010,
        ST_REC  = 3'b100
    } racq_state_t;

    typedef struct packed {
        logic [NCH-1:0]       hit;
        logic [NCH-1:0]       pileup;
        logic [NCH-1:0]       oor;
        logic [NCH-1:0]       gate;
        logic                 veto;
        logic [NCH-1:0][15:0] energy;
    } racq_event_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic [14:0] bin;
    } racq_hist_t;

    typedef struct packed {
        logic [23:0] sum_a;
        logic [23:0] sum_b;
        logic [15:0] amp;
        logic [15:0] ratio;
    } racq_psa_t;

    typedef struct packed {
        logic        valid;
        logic        group;
        logic [1:0]  chan;
        logic [15:0] hit_pattern;
        logic [17:0] energy;
        racq_psa_t   pulse_shape_result;
        logic [15:0] trace_words;
    } racq_rec_t;
endpackage : racq_pkg

// ---- racq_asserts.sv ----
// Port checks for the acquisition control block
`timescale 1ns/100ps
module racq_asserts #(parameter int BUF_WORDS = 256, parameter int SPILL_WORDS = 16) (
    input wire logic            clk_i, rst_i, psel_i, penable_i, pslverr_o, ev_ready_o,
    input wire logic            led_red_o, drain_i, drain_ready_o, spill_done_o,
    input wire logic [7:0]      paddr_i,
    input wire logic [31:0]     rd_ptr_o,
    input racq_pkg::racq_hist_t hist_o,
    input racq_pkg::racq_rec_t  rec_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_led_pause: assert property (led_red_o |-> !ev_ready_o) else $error("led lit, ready");
    a_drain_step: assert property (drain_i && drain_ready_o |=>
        rd_ptr_o == ($past(rd_ptr_o) + 1) % BUF_WORDS) else $error("read position step");
    a_drain_empty: assert property (drain_i && !drain_ready_o |=> $stable(rd_ptr_o))
        else $error("drained empty buffer");
    a_spill_once: assert property (spill_done_o |=> !spill_done_o) else $error("spill long");
    a_spill_bound: assert property (spill_done_o |-> rd_ptr_o % SPILL_WORDS == 0 ||
        $past(rd_ptr_o) % SPILL_WORDS == 0) else $error("spill off boundary");
    a_hist_busy: assert property (hist_o.valid |-> $past(!ev_ready_o)) else $error("hist idle");
    a_rec_busy: assert property (rec_o.valid |-> $past(!ev_ready_o)) else $error("rec idle");
    a_err_map: assert property (psel_i && penable_i && paddr_i > 8'h2C |-> pslverr_o)
        else $error("unmapped no error");
    // Main scenarios reached
    c_spill: cover property (spill_done_o);
    c_rec: cover property (rec_o.valid);
    c_full: cover property (led_red_o);
endmodule : racq_asserts
bind racq_top racq_asserts #(.BUF_WORDS(BUF_WORDS), .SPILL_WORDS(SPILL_WORDS)) u_chk (.*);

// ---- racq_host.sv ----
// Host model draining the list buffer and counting spills
`timescale 1ns/100ps
module racq_host (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   stall_i,
    input  wire logic   slow_i,
    input  wire logic   spill_done_i,
    output logic        drain_o,
    output logic [31:0] spills_o
);
    // Keeps pulling after a stop; stall models a busy host, slow halves the rate
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drain_o  <= 1'b0;
            spills_o <= 32'h0000_0000;
        end else begin
            drain_o <= !stall_i && (!slow_i || !drain_o);
            if (spill_done_i) spills_o <= spills_o + 1;
        end
    end
endmodule : racq_host

// ---- racq_top_bench.sv ----
// Self-checking bench for the acquisition control block
`timescale 1ns/100ps
module racq_top_bench;
    logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, ev_valid_i = 0;
    logic stall = 0, slow = 0, err, pready_o, pslverr_o, ev_ready_o, drain_i, drain_ready_o;
    logic spill_done_o, group_trig_o, trace_capture_o, led_red_o;
    logic [7:0] paddr_i = 0;
    logic [3:0] trig = 0, oor = 0;
    logic [31:0] wrp, rdp;
    logic [31:0] pwdata_i = 0, prdata_o, rd, spills;
    logic [3:0][15:0] sample_i = '0;
    racq_pkg::racq_event_t ev_i = '0;
    racq_pkg::racq_hist_t hist_o;
    racq_pkg::racq_rec_t rec_o;
    logic [15:0] codes [4] = '{racq_pkg::RT_MCA, racq_pkg::RT_LIST, racq_pkg::RT_TEXT,
        racq_pkg::RT_GROUP};
    int n_fail = 0, check_count = 0, cyc = 0, nh = 0, nr = 0, tot = 0, t;
    racq_top #(.BUF_WORDS(256), .SPILL_WORDS(16)) dut (.*, .baseline_i('0), .trig_i(trig),
        .chan_oor_i(oor), .chan_buf_full_i(4'h0), .pulse_shape_result_o(), .wr_ptr_o(wrp),
        .rd_ptr_o(rdp));
    racq_host host (.clk_i, .rst_i, .stall_i(stall), .slow_i(slow), .spill_done_i(spill_done_o),
        .drain_o(drain_i), .spills_o(spills));
    initial forever #5 clk_i = ~clk_i;
    // Pulse counting, live samples and hang limit
    always @(posedge clk_i) begin
        cyc++;
        nh += hist_o.valid;
        nr += rec_o.valid;
        sample_i <= {$urandom, $urandom};
        trig <= 4'($urandom);
        if (cyc == 30000) begin n_fail++; report_and_stop(); end
    end
    function automatic int n_rec(logic [15:0] c); // records per event of hits 0101 or 1111
        return c == racq_pkg::RT_MCA ? 0 : c == racq_pkg::RT_GROUP ? 1 : 2;
    endfunction : n_rec
    function automatic int n_words(logic [15:0] c); // trace length 8 is set below
        return c == racq_pkg::RT_TEXT ? 16 : c == racq_pkg::RT_GROUP ? 96 : 24;
    endfunction : n_words
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin n_fail++; $display("Error at %0t: %h not %h", $time, got, exp); end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i) penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o; err = pslverr_o; psel_i <= 0; penable_i <= 0;
        @(posedge clk_i);
    endtask : apb
    task automatic ev(input logic [3:0] h);
        while (ev_ready_o !== 1'b1) @(posedge clk_i);
        ev_valid_i <= 1; ev_i.hit <= h; ev_i.energy <= {$urandom, $urandom};
        @(posedge clk_i) ev_valid_i <= 0;
        @(posedge clk_i);
        // A full buffer leaves ready low; stop waiting once the pause shows
        while (ev_ready_o !== 1'b1 && led_red_o !== 1'b1) @(posedge clk_i);
        @(posedge clk_i);
    endtask : ev
    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        void'($urandom(32'h72b6_980d));
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        apb(0, racq_pkg::OFS_TASK, 0); chk(rd, 32'h0000_0301);
        apb(0, 8'h30, 0); chk({rd, err}, 33'h0_0000_0001);
        apb(1, racq_pkg::OFS_BIN, 2); apb(1, racq_pkg::OFS_TRACE, 8);
        foreach (codes[i]) begin
            oor <= codes[i] == racq_pkg::RT_GROUP ? 4'h2 : 4'h0;
            apb(1, racq_pkg::OFS_TASK, codes[i]); apb(1, racq_pkg::OFS_CTRL, 1); nh = 0; nr = 0;
            ev(codes[i] == racq_pkg::RT_GROUP ? 4'hF : 4'h5); tot += n_rec(codes[i]) * n_words(codes[i]);
            chk(nr, n_rec(codes[i]));
            chk(nh, codes[i] == racq_pkg::RT_GROUP ? 5 : 2);
            chk(group_trig_o, codes[i] == racq_pkg::RT_GROUP);
            if (codes[i] == racq_pkg::RT_TEXT) chk(trace_capture_o, 0);
            apb(0, racq_pkg::OFS_STATUS, 0); chk(rd[0], 1);
            apb(0, racq_pkg::OFS_LIVE0, 0); chk(rd != 0, codes[i] != racq_pkg::RT_GROUP);
            apb(1, racq_pkg::OFS_CTRL, 2);
        end
        stall <= 1; apb(1, racq_pkg::OFS_TASK, racq_pkg::RT_LIST); apb(1, racq_pkg::OFS_CTRL, 1);
        for (int i = 0; i < 40 && led_red_o !== 1'b1; i++) begin ev(4'h1); tot += 24; end
        chk({led_red_o, ev_ready_o}, 2'b10);
        stall <= 0;
        for (t = 0; led_red_o !== 1'b0 && t < 600; t++) @(posedge clk_i);
        chk(led_red_o, 0); apb(1, racq_pkg::OFS_CTRL, 2); slow <= 1;
        for (t = 0; drain_ready_o !== 1'b0 && t < 3000; t++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        chk(spills, tot / 16);
        chk(wrp, tot % 256); chk(rdp, tot % 256);
        report_and_stop();
    end
endmodule : racq_top_bench
